// file: pkg/insn_decode_pkg.sv
// Package holding field layouts, opcode encodings and timing constants for the decoder.
package insn_decode_pkg;
   localparam int INSN_WIDTH = 14;
   localparam int FILE_ADDR_WIDTH = 7;
   localparam int BIT_SEL_WIDTH = 3;
   localparam int DATA_WIDTH = 8;
   localparam int LIT8_WIDTH = 8;
   localparam int LIT11_WIDTH = 11;
   localparam int Q_PHASES = 4;
   localparam logic [1:0] Q_LAST = 2'h3;
   localparam logic [1:0] Q_READ = 2'h1;
   localparam logic [1:0] Q_MODIFY = 2'h2;
   localparam logic [1:0] Q_WRITE = 2'h3;
   localparam logic [1:0] Q_FIRST = 2'h0;
   localparam int GROUP_MSB = 13;
   localparam int GROUP_LSB = 12;
   localparam int DEST_BIT = 7;
   localparam int BIT_SEL_MSB = 9;
   localparam int BIT_SEL_LSB = 7;
   localparam int BYTE_OP_MSB = 11;
   localparam int BYTE_OP_LSB = 8;
   localparam int BIT_OP_MSB = 11;
   localparam int BIT_OP_LSB = 10;
   localparam int LIT_OP_MSB = 11;
   localparam int LIT_OP_LSB = 8;
   localparam logic [1:0] GRP_BYTE = 2'h0;
   localparam logic [1:0] GRP_BIT = 2'h1;
   localparam logic [1:0] GRP_JUMP = 2'h2;
   localparam logic [1:0] GRP_LIT = 2'h3;
   localparam logic [3:0] OP_MOVWF = 4'h0;
   localparam logic [3:0] OP_CLR = 4'h1;
   localparam logic [3:0] OP_SUB = 4'h2;
   localparam logic [3:0] OP_DEC = 4'h3;
   localparam logic [3:0] OP_IOR = 4'h4;
   localparam logic [3:0] OP_AND = 4'h5;
   localparam logic [3:0] OP_XOR = 4'h6;
   localparam logic [3:0] OP_ADD = 4'h7;
   localparam logic [3:0] OP_MOV = 4'h8;
   localparam logic [3:0] OP_COM = 4'h9;
   localparam logic [3:0] OP_INC = 4'hA;
   localparam logic [3:0] OP_DECSZ = 4'hB;
   localparam logic [3:0] OP_RRF = 4'hC;
   localparam logic [3:0] OP_RLF = 4'hD;
   localparam logic [3:0] OP_SWAP = 4'hE;
   localparam logic [3:0] OP_INCSZ = 4'hF;
   localparam logic [1:0] BOP_CLR = 2'h0;
   localparam logic [1:0] BOP_SET = 2'h1;
   localparam logic [1:0] BOP_TSC = 2'h2;
   localparam logic [1:0] BOP_TSS = 2'h3;
   localparam logic [DATA_WIDTH-1:0] BYTE_ZERO = 8'h00;
   localparam logic [DATA_WIDTH-1:0] BYTE_ONE = 8'h01;

   typedef enum logic [1:0] {
      GROUP_BYTE,
      GROUP_BIT,
      GROUP_LITERAL
   } group_type;

   typedef struct packed {
      group_type group;
      logic [3:0] opcode;
      logic [FILE_ADDR_WIDTH-1:0] file_addr;
      logic dest_file;
      logic [BIT_SEL_WIDTH-1:0] bit_sel;
      logic [LIT8_WIDTH-1:0] lit8;
      logic [LIT11_WIDTH-1:0] lit11;
      logic uses_file;
      logic is_jump;
   } fields_type;

   typedef struct packed {
      logic active;
      logic [FILE_ADDR_WIDTH-1:0] addr;
      logic [DATA_WIDTH-1:0] data;
   } file_access_type;
endpackage : insn_decode_pkg

// file: core/insn_field_split.sv
// Combinational split of a 14-bit instruction word into its operand fields.
`timescale 1ns/10ps
module insn_field_split (
   input wire logic [insn_decode_pkg::INSN_WIDTH-1:0] i_word,
   output insn_decode_pkg::fields_type o_fields
);
   import insn_decode_pkg::*;

   always_comb begin
      o_fields = '0;
      o_fields.file_addr = i_word[FILE_ADDR_WIDTH-1:0];
      o_fields.dest_file = i_word[DEST_BIT];
      o_fields.bit_sel = i_word[BIT_SEL_MSB:BIT_SEL_LSB];
      o_fields.lit8 = i_word[LIT8_WIDTH-1:0];
      o_fields.lit11 = i_word[LIT11_WIDTH-1:0];
      o_fields.opcode = i_word[BYTE_OP_MSB:BYTE_OP_LSB];
      unique case (i_word[GROUP_MSB:GROUP_LSB])
         GRP_BYTE: begin
            o_fields.group = GROUP_BYTE;
            // Opcode zero with d clear is the idle and control family, which names no file.
            o_fields.uses_file = !(i_word[BYTE_OP_MSB:BYTE_OP_LSB] == OP_MOVWF
               && !i_word[DEST_BIT]);
         end
         GRP_BIT: begin
            o_fields.group = GROUP_BIT;
            o_fields.opcode = {2'h0, i_word[BIT_OP_MSB:BIT_OP_LSB]};
            o_fields.uses_file = 1'b1;
         end
         GRP_JUMP: begin
            o_fields.group = GROUP_LITERAL;
            o_fields.is_jump = 1'b1;
         end
         GRP_LIT: begin
            o_fields.group = GROUP_LITERAL;
         end
      endcase
   end
endmodule : insn_field_split

// file: core/insn_decode_execute_timing.sv
// Instruction decode, four-phase cycle timing and read-modify-write execution.
//
// Behaviour
// - Each instruction is a 14-bit word made of an opcode plus operand fields.
// - Each instruction is sorted into byte, bit or literal/control groups.
// - Byte operations write to the working register when d is 0, else to the file; opcode zero with d clear writes neither.
// - Byte operations take their operand from the file selected by the f field.
// - Bit operations act on the bit chosen by b inside the file chosen by f.
// - Literal operations use an eight-bit or eleven-bit constant from the word.
// - An instruction cycle is four consecutive oscillator periods.
// - An instruction finishes in one cycle unless it skips or changes the counter.
// - A taken skip or counter change costs a second cycle run as a no-operation.
// - Every file write is a read, modify and write back, even for write-only ops.
// - The file select field is seven bits wide, covering addresses 0 to 0x7F.
// - The bit select field is three bits, naming one bit of an eight-bit register.
`timescale 1ns/10ps
module insn_decode_execute_timing (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [insn_decode_pkg::INSN_WIDTH-1:0] i_insn,
   input wire logic [insn_decode_pkg::DATA_WIDTH-1:0] i_file_rdata,
   output logic [1:0] o_phase,
   output logic o_fetch,
   output logic o_file_read,
   output logic [insn_decode_pkg::FILE_ADDR_WIDTH-1:0] o_file_addr,
   output logic o_file_write,
   output logic [insn_decode_pkg::DATA_WIDTH-1:0] o_file_wdata,
   output logic [insn_decode_pkg::DATA_WIDTH-1:0] o_work,
   output logic o_pc_load,
   output logic [insn_decode_pkg::LIT11_WIDTH-1:0] o_pc_target,
   output logic o_no_operation,
   output logic o_insn_done
);
   import insn_decode_pkg::*;

   typedef enum logic [1:0] {
      EXEC,
      FLUSH
   } cycle_state_type;

   fields_type fields;
   fields_type fields_q, fields_d;
   cycle_state_type state_q, state_d;
   logic [1:0] phase_q, phase_d;
   logic [DATA_WIDTH-1:0] work_q, work_d;
   logic [DATA_WIDTH-1:0] operand_q, operand_d;
   logic fetch_q, fetch_d;
   logic rd_q, rd_d;
   logic wr_q, wr_d;
   logic [DATA_WIDTH-1:0] wdata_q, wdata_d;
   logic pc_load_q, pc_load_d;
   logic [LIT11_WIDTH-1:0] pc_target_q, pc_target_d;
   logic no_operation_q, no_operation_d;
   logic done_q, done_d;
   logic [DATA_WIDTH-1:0] result;
   logic to_file;
   logic to_work;
   logic skip;

   insn_field_split u_split (
      .i_word(i_insn),
      .o_fields(fields)
   );

   function automatic logic [DATA_WIDTH-1:0] bit_mask(input logic [BIT_SEL_WIDTH-1:0] sel);
      bit_mask = BYTE_ONE << sel;
   endfunction : bit_mask

   // Byte and bit datapath; carry is not modelled here, so rotates bring in zero.
   always_comb begin
      result = operand_q;
      to_file = 1'b0;
      to_work = 1'b0;
      skip = 1'b0;
      unique case (fields_q.group)
         GROUP_BYTE: begin
            to_file = fields_q.dest_file;
            to_work = !fields_q.dest_file;
            unique case (fields_q.opcode)
               OP_MOVWF: begin
                  result = work_q;
                  to_file = fields_q.dest_file;
                  to_work = 1'b0;
               end
               OP_CLR: result = BYTE_ZERO;
               OP_SUB: result = operand_q - work_q;
               OP_DEC: result = operand_q - BYTE_ONE;
               OP_IOR: result = operand_q | work_q;
               OP_AND: result = operand_q & work_q;
               OP_XOR: result = operand_q ^ work_q;
               OP_ADD: result = operand_q + work_q;
               OP_MOV: result = operand_q;
               OP_COM: result = ~operand_q;
               OP_INC: result = operand_q + BYTE_ONE;
               OP_DECSZ: begin
                  result = operand_q - BYTE_ONE;
                  skip = (result == BYTE_ZERO);
               end
               OP_RRF: result = {1'b0, operand_q[DATA_WIDTH-1:1]};
               OP_RLF: result = {operand_q[DATA_WIDTH-2:0], 1'b0};
               OP_SWAP: result = {operand_q[3:0], operand_q[7:4]};
               OP_INCSZ: begin
                  result = operand_q + BYTE_ONE;
                  skip = (result == BYTE_ZERO);
               end
            endcase
         end
         GROUP_BIT: begin
            unique case (fields_q.opcode[1:0])
               BOP_CLR: begin
                  result = operand_q & ~bit_mask(fields_q.bit_sel);
                  to_file = 1'b1;
               end
               BOP_SET: begin
                  result = operand_q | bit_mask(fields_q.bit_sel);
                  to_file = 1'b1;
               end
               BOP_TSC: skip = (operand_q & bit_mask(fields_q.bit_sel)) == BYTE_ZERO;
               BOP_TSS: skip = (operand_q & bit_mask(fields_q.bit_sel)) != BYTE_ZERO;
            endcase
         end
         GROUP_LITERAL: begin
            // Literal ops take the low eight bits; jumps take eleven.
            to_work = !fields_q.is_jump;
            unique case (fields_q.opcode[3:2])
               2'h0: result = fields_q.lit8;
               2'h1: result = fields_q.lit8;
               2'h2: result = fields_q.opcode[0] ? (work_q & fields_q.lit8)
                                                 : (work_q | fields_q.lit8);
               2'h3: result = work_q + fields_q.lit8;
            endcase
            if (fields_q.opcode[3:1] == 3'h5) begin
               result = work_q ^ fields_q.lit8;
            end
            if (fields_q.opcode[3:1] == 3'h6) begin
               result = fields_q.lit8 - work_q;
            end
         end
         default: begin
            result = operand_q;
         end
      endcase
   end

   always_comb begin
      state_d = state_q;
      phase_d = phase_q + 2'h1;
      fields_d = fields_q;
      work_d = work_q;
      operand_d = operand_q;
      fetch_d = 1'b0;
      rd_d = 1'b0;
      wr_d = 1'b0;
      wdata_d = wdata_q;
      pc_load_d = 1'b0;
      pc_target_d = pc_target_q;
      no_operation_d = no_operation_q;
      done_d = 1'b0;
      unique case (phase_q)
         Q_FIRST: begin
            if (state_q == EXEC) begin
               fields_d = fields;
               rd_d = fields.uses_file;
               no_operation_d = 1'b0;
            end else begin
               no_operation_d = 1'b1;
            end
         end
         Q_READ: begin
            if (state_q == EXEC && fields_q.uses_file) begin
               operand_d = i_file_rdata;
            end
         end
         Q_MODIFY: begin
            if (state_q == EXEC) begin
               wr_d = to_file;
               wdata_d = result;
               if (to_work) begin
                  work_d = result;
               end
               if (fields_q.is_jump) begin
                  pc_load_d = 1'b1;
                  pc_target_d = fields_q.lit11;
               end
            end
         end
         Q_LAST: begin
            fetch_d = 1'b1;
            if (state_q == EXEC && (skip || fields_q.is_jump)) begin
               state_d = FLUSH;
            end else begin
               state_d = EXEC;
               done_d = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         state_q <= EXEC;
         phase_q <= Q_FIRST;
         fields_q <= '0;
         work_q <= BYTE_ZERO;
         operand_q <= BYTE_ZERO;
         fetch_q <= 1'b0;
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         wdata_q <= BYTE_ZERO;
         pc_load_q <= 1'b0;
         pc_target_q <= '0;
         no_operation_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         state_q <= state_d;
         phase_q <= phase_d;
         fields_q <= fields_d;
         work_q <= work_d;
         operand_q <= operand_d;
         fetch_q <= fetch_d;
         rd_q <= rd_d;
         wr_q <= wr_d;
         wdata_q <= wdata_d;
         pc_load_q <= pc_load_d;
         pc_target_q <= pc_target_d;
         no_operation_q <= no_operation_d;
         done_q <= done_d;
      end
   end

   assign o_phase = phase_q;
   assign o_fetch = fetch_q;
   assign o_file_read = rd_q;
   assign o_file_addr = fields_q.file_addr;
   assign o_file_write = wr_q;
   assign o_file_wdata = wdata_q;
   assign o_work = work_q;
   assign o_pc_load = pc_load_q;
   assign o_pc_target = pc_target_q;
   assign o_no_operation = no_operation_q;
   assign o_insn_done = done_q;
endmodule : insn_decode_execute_timing

// file: tb/insn_decode_props.sv
// Checker for cycle timing, flush behaviour and read-modify-write ordering.
`timescale 1ns/10ps
module insn_decode_props (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [13:0] i_insn,
   input wire logic [1:0] o_phase,
   input wire logic o_file_read,
   input wire logic [6:0] o_file_addr,
   input wire logic o_file_write,
   input wire logic o_pc_load,
   input wire logic [10:0] o_pc_target,
   input wire logic o_no_operation,
   input wire logic o_insn_done
);
   wire logic [1:0] grp_w = i_insn[13:12];
   wire logic [6:0] faddr_w = i_insn[6:0];
   wire logic [10:0] k11_w = i_insn[10:0];
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_rst);
   phase_step_a: assert property (!i_rst |=> o_phase == $past(o_phase) + 2'h1)
      else $error("phase did not advance by one");
   read_source_a: assert property (o_file_read |-> o_phase == 2'h1 &&
      o_file_addr == $past(faddr_w) && !$past(grp_w[1])) else $error("bad file read");
   rmw_order_a: assert property (o_file_write |-> o_phase == 2'h3 &&
      $past(o_file_read, 2) && o_file_addr == $past(o_file_addr, 2)) else $error("write w/o read");
   jump_flush_a: assert property (o_pc_load |-> ##2 o_no_operation[*4])
      else $error("jump not followed by idle cycle");
   flush_quiet_a: assert property (o_no_operation |->
      !(o_file_read || o_file_write || o_pc_load)) else $error("activity in idle cycle");
   flush_length_a: assert property ($rose(o_no_operation) |->
      o_phase == 2'h1 ##0 o_no_operation[*4] ##1 !o_no_operation) else $error("idle length");
   done_pulse_a: assert property (o_insn_done |->
      o_phase == 2'h0 ##1 (!o_insn_done)[*3]) else $error("done pulse misplaced");
   jump_target_a: assert property (o_pc_load |-> o_phase == 2'h3 &&
      o_pc_target == $past(k11_w, 3) && $past(grp_w, 3) == 2'h2) else $error("bad jump target");
endmodule : insn_decode_props

bind insn_decode_execute_timing insn_decode_props props_i (.i_clock, .i_rst, .i_insn, .o_phase,
   .o_file_read, .o_file_addr, .o_file_write, .o_pc_load, .o_pc_target, .o_no_operation,
   .o_insn_done);

// file: tb/insn_mem_model.sv
// Program memory and file register model facing the decoder.
`timescale 1ns/10ps
module insn_mem_model (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [1:0] i_phase,
   input wire logic i_file_read,
   input wire logic [6:0] i_file_addr,
   input wire logic i_file_write,
   input wire logic [7:0] i_file_wdata,
   output logic [13:0] o_insn,
   output logic [7:0] o_file_rdata
);
   logic [13:0] prog [256];
   logic [7:0] file [128];
   logic [7:0] ptr_q;
   logic [7:0] last_q;
   // Outside the fetch slot the word is inverted, so a late sample shows up as garbage.
   assign o_insn = (i_phase == 2'h0) ? prog[ptr_q] : ~prog[ptr_q];
   assign o_file_rdata = i_file_read ? file[i_file_addr] : ~last_q;
   // Every slot consumes one word, so a skipped word is simply never executed.
   always @(posedge i_clock or posedge i_rst) begin
      if (i_rst) begin
         ptr_q <= 8'h00;
         last_q <= 8'h00;
      end else begin
         if (i_phase == 2'h0) ptr_q <= ptr_q + 8'h01;
         if (i_file_read) last_q <= file[i_file_addr];
         if (i_file_write) file[i_file_addr] <= i_file_wdata;
      end
   end
endmodule : insn_mem_model

// file: tb/insn_decode_execute_timing_tb.sv
// Self-checking bench running a random program against a cycle model.
`timescale 1ns/10ps
module insn_decode_execute_timing_tb;
   logic i_clock;
   logic i_rst;
   logic [13:0] i_insn;
   logic [7:0] i_file_rdata, o_file_wdata, o_work;
   logic [1:0] o_phase;
   logic o_fetch, o_file_read, o_file_write, o_pc_load, o_no_operation, o_insn_done;
   logic [6:0] o_file_addr;
   logic [10:0] o_pc_target;
   int n_fail, tests_run, slots;
   logic [13:0] ins;
   logic [7:0] wreg, res, fv;
   logic flsh, nxtf, uf, wrf, jmp, started;
   logic [13:0] corner [8] = '{14'h30A5, 14'h00FF, 14'h0BFF, 14'h1FFF,
      14'h2800, 14'h2FFF, 14'h3FFF, 14'h0180};

   insn_decode_execute_timing dut (.i_clock(i_clock), .i_rst(i_rst), .i_insn(i_insn),
      .i_file_rdata(i_file_rdata), .o_phase(o_phase), .o_fetch(o_fetch),
      .o_file_read(o_file_read),
      .o_file_addr(o_file_addr), .o_file_write(o_file_write), .o_file_wdata(o_file_wdata),
      .o_work(o_work), .o_pc_load(o_pc_load), .o_pc_target(o_pc_target),
      .o_no_operation(o_no_operation), .o_insn_done(o_insn_done));
   insn_mem_model mem_i (.i_clock(i_clock), .i_rst(i_rst), .i_phase(o_phase),
      .i_file_read(o_file_read), .i_file_addr(o_file_addr), .i_file_write(o_file_write),
      .i_file_wdata(o_file_wdata), .o_insn(i_insn), .o_file_rdata(i_file_rdata));

   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   task automatic report_and_stop();
      $display("checks=%0d failures=%0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : report_and_stop

   function automatic logic [7:0] byte_expect(input logic [3:0] op, input logic [7:0] f,
         input logic [7:0] w);
      case (op)
         4'h0: byte_expect = w;
         4'h1: byte_expect = 8'h00;
         4'h2: byte_expect = f - w;
         4'h3, 4'hB: byte_expect = f - 8'h01;
         4'h4: byte_expect = f | w;
         4'h5: byte_expect = f & w;
         4'h6: byte_expect = f ^ w;
         4'h7: byte_expect = f + w;
         4'h8: byte_expect = f;
         4'h9: byte_expect = ~f;
         4'hC: byte_expect = {1'b0, f[7:1]};
         4'hD: byte_expect = {f[6:0], 1'b0};
         4'hE: byte_expect = {f[3:0], f[7:4]};
         default: byte_expect = f + 8'h01;
      endcase
   endfunction : byte_expect

   function automatic logic [7:0] lit_expect(input logic [3:0] op, input logic [7:0] k,
         input logic [7:0] w);
      casez (op)
         4'b0???: lit_expect = k;
         4'h8: lit_expect = k | w;
         4'h9: lit_expect = k & w;
         4'b101?: lit_expect = k ^ w;
         4'b110?: lit_expect = k - w;
         default: lit_expect = k + w;
      endcase
   endfunction : lit_expect

   initial begin
      i_clock = 1'b0;
      forever #2.5 i_clock = ~i_clock;
   end

   // Outputs are read before this edge's updates land, so each phase shows its own slot.
   always @(posedge i_clock) begin
      if (!i_rst) begin
         case (o_phase)
            2'h0: begin
               if (started) check(o_work, wreg);
               if (started) check(o_insn_done, !nxtf);
               if (started) check(o_fetch, 1'b1);
               started = 1'b1;
               slots++;
               ins = i_insn;
               flsh = nxtf;
               nxtf = 1'b0;
               wrf = 1'b0;
               uf = !flsh && (ins[13:12] == 2'h1 ||
                  (ins[13:12] == 2'h0 && (ins[11:8] != 4'h0 || ins[7])));
               jmp = !flsh && ins[13:12] == 2'h2;
            end
            2'h1: begin
               check(o_file_read, uf);
               check(o_fetch, 1'b0);
               if (uf) check(o_file_addr, ins[6:0]);
               if (flsh) check(o_no_operation, 1'b1);
               fv = mem_i.file[ins[6:0]];
               if (!flsh) begin
                  case (ins[13:12])
                     2'h0: begin
                        res = byte_expect(ins[11:8], fv, wreg);
                        nxtf = (ins[11:8] == 4'hB || ins[11:8] == 4'hF) && res == 8'h00;
                        wrf = ins[7];
                        if (!ins[7]) wreg = res;
                     end
                     2'h1: begin
                        res = fv;
                        res[ins[9:7]] = ins[10];
                        wrf = !ins[11];
                        nxtf = ins[11] && fv[ins[9:7]] == ins[10];
                     end
                     2'h2: nxtf = 1'b1;
                     default: begin
                        wreg = lit_expect(ins[11:8], ins[7:0], wreg);
                     end
                  endcase
               end
            end
            2'h3: begin
               check(o_file_write, wrf);
               if (wrf) check(o_file_wdata, res);
               check(o_pc_load, jmp);
               if (jmp) check(o_pc_target, ins[10:0]);
            end
            default: ;
         endcase
      end
   end

   initial begin
      i_rst = 1'b1;
      n_fail = 0;
      tests_run = 0;
      slots = 0;
      started = 1'b0;
      nxtf = 1'b0;
      wreg = 8'h00;
      void'($urandom(23));
      for (int i = 0; i < 256; i++) mem_i.prog[i] = 14'($urandom);
      for (int i = 0; i < 128; i++) mem_i.file[i] = 8'($urandom);
      for (int i = 0; i < 8; i++) mem_i.prog[i] = corner[i];
      repeat (12) @(posedge i_clock);
      i_rst <= 1'b0;
      repeat (1200) @(posedge i_clock);
      // A stalled phase counter would starve the per-phase checks, so count the slots too.
      check(16'(slots), 16'd300);
      report_and_stop();
   end
endmodule : insn_decode_execute_timing_tb
